// file: logic/config_bank_consts.vh
// Constants for the index/data configuration register bank.
// Assumes inclusion by bare name from the design file only.
`ifndef CONFIG_BANK_CONSTS_VH
`define CONFIG_BANK_CONSTS_VH

// Indexes of the eight configuration registers
`define IDX_FUNCTION_ENABLE 3'h0
`define IDX_FUNCTION_BASE_ADDRESS 3'h1
`define IDX_POWER_AND_TEST 3'h2
`define IDX_FUNCTION_CONTROL 3'h3
`define IDX_PRINTER_PORT_CONTROL 3'h4
`define IDX_POWER_MANAGEMENT_CONTROL 3'h5
`define IDX_TAPE_SERIAL_PARALLEL_CONFIG 3'h6
`define IDX_CHIP_IDENTIFICATION 3'h7

// Host I/O address bit: 0 selects index, 1 selects data
`define PORT_INDEX 1'b0
`define PORT_DATA 1'b1

// Function numbers (bit positions in enable and power fields)
`define FN_FLOPPY 3'h0
`define FN_SERIAL_A 3'h1
`define FN_SERIAL_B 3'h2
`define FN_PRINTER 3'h3
`define FN_IDE 3'h4

// Every function powered down, tristated and blocked
`define FN_ALL_OFF 5'h1F

// Field positions in power_management_control
`define PWR_MGMT_TRISTATE_LSB 0
`define PWR_MGMT_BLOCK_LSB 4

// Field positions in function_base_address
`define BASE_SEL_PRINTER_LSB 0
`define BASE_SEL_SERIAL_A_LSB 2
`define BASE_SEL_SERIAL_B_LSB 4

// Chip-wide power-down bit in power_and_test
`define CHIP_DOWN_BIT 0

// Address window widths for the decode function
`define WIN_8 1'b1
`define WIN_4 1'b0

// Standard AT base addresses (10-bit I/O)
`define BASE_FLOPPY 10'h3F0
`define BASE_IDE 10'h1F0
`define BASE_COM1 10'h3F8
`define BASE_COM2 10'h2F8
`define BASE_COM3 10'h3E8
`define BASE_COM4 10'h2E8
`define BASE_LPT1 10'h3BC
`define BASE_LPT2 10'h378
`define BASE_LPT3 10'h278

`define INDEX_RESET 8'h00

// Idle strobe image {addr0, read_n, write_n, chip_select_n}
`define SYNC_IDLE 4'h7

`endif

// file: logic/index_data_config_registers.v
// Index/data configuration register bank with per-function power controls.
// Assumes host strobes arrive asynchronous to clk; straps hold steady during reset.
`timescale 1ns/1ps
`include "config_bank_consts.vh"

// How it works
// - Eight byte registers selected by index 0-7
// - Reset clears the eight config registers, which load from strap inputs on the first clock after release; index clears to 0
// - Index write picks register for data accesses
// - Data write updates, read returns indexed register
// - Only two host addresses: index and data
// - Disabled function powers down, keeps its data
// - Decode AT bases; serial picks one of four, printer one of three
// - Separate power-down per function; tristate, input block for functions 0-3 only
module index_data_config_registers (
    input wire clk,
    input wire resetn,
    input wire [63:0] strap_defaults,
    input wire io_addr0,
    input wire io_chip_select_n,
    input wire io_write_n,
    input wire io_read_n,
    input wire [7:0] io_data_in,
    output reg [7:0] io_data_out,
    output reg io_data_oe,
    input wire [9:0] host_addr,
    output reg [4:0] function_power_down,
    output reg [4:0] function_pins_tristate,
    output reg [4:0] function_inputs_blocked,
    output reg [4:0] function_select,
    output reg [63:0] config_image
);

////////////////////////////////////////////////////////////////////////////////
// Synchronise host strobes; edges are taken only from the second stage

reg [3:0] sync_a;
reg [3:0] sync_b;
reg wr_prev;
reg rd_prev;
reg [7:0] data_sync_a;
reg [7:0] data_sync_b;
wire cs_s = ~sync_b[0];
wire addr_s = sync_b[3];
wire wr_level = cs_s & ~sync_b[1];
wire rd_level = cs_s & ~sync_b[2];
// Write commits at strobe release so data has long settled
wire wr_done = wr_prev & ~wr_level;
wire rd_start = rd_level & ~rd_prev;

// Straps are pins too; these stages carry no reset so they keep sampling
// through reset and hold settled values by the first clock after release.
reg [63:0] strap_s1;
reg [63:0] strap_s2;

always @(posedge clk) begin
    strap_s1 <= strap_defaults;
    strap_s2 <= strap_s1;
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        sync_a <= `SYNC_IDLE;
        sync_b <= `SYNC_IDLE;
        wr_prev <= 1'b0;
        rd_prev <= 1'b0;
        data_sync_a <= 8'h00;
        data_sync_b <= 8'h00;
    end else begin
        sync_a <= {io_addr0, io_read_n, io_write_n, io_chip_select_n};
        sync_b <= sync_a;
        wr_prev <= wr_level;
        rd_prev <= rd_level;
        data_sync_a <= io_data_in;
        data_sync_b <= data_sync_a;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Index register and the eight configuration registers

reg [7:0] index_reg;
reg [7:0] cfg [0:7];
reg load_straps;
integer i;
integer j;

// Only three index bits select; upper bits read back as written
function [7:0] read_cfg;
    input [7:0] idx;
    begin
        read_cfg = cfg[idx[2:0]];
    end
endfunction

// Straps cannot be copied under asynchronous reset, so they are loaded
// on the first clock after release, while the host still holds off.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        load_straps <= 1'b1;
        index_reg <= `INDEX_RESET;
        for (i = 0; i < 8; i = i + 1) begin
            cfg[i] <= 8'h00;
        end
    end else begin
        load_straps <= 1'b0;
        if (load_straps) begin
            for (i = 0; i < 8; i = i + 1) begin
                cfg[i] <= strap_s2[i*8 +: 8];
            end
        end else if (wr_done) begin
            if (addr_s == `PORT_INDEX) begin
                index_reg <= data_sync_b;
            end else begin
                cfg[index_reg[2:0]] <= data_sync_b;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Host read path

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        io_data_out <= 8'h00;
        io_data_oe <= 1'b0;
    end else begin
        io_data_oe <= rd_level;
        if (rd_start) begin
            // Index port reads return all eight bits, unused ones included
            if (addr_s == `PORT_INDEX) begin
                io_data_out <= index_reg;
            end else begin
                io_data_out <= read_cfg(index_reg);
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-function power controls and AT address decode

wire [7:0] enables = cfg[`IDX_FUNCTION_ENABLE];
wire [7:0] base_sel = cfg[`IDX_FUNCTION_BASE_ADDRESS];
wire [7:0] power_ctl = cfg[`IDX_POWER_MANAGEMENT_CONTROL];
wire chip_down = cfg[`IDX_POWER_AND_TEST][`CHIP_DOWN_BIT];

// Window match against a base: eight ports, or four for the printer
function addr_hit;
    input [9:0] addr;
    input [9:0] base;
    input wide;
    begin
        if (wide) begin
            addr_hit = addr[9:3] == base[9:3];
        end else begin
            addr_hit = addr[9:2] == base[9:2];
        end
    end
endfunction

// Pick one of four bases from a select bit pair
function [9:0] pick_base;
    input [1:0] sel;
    input [9:0] b0;
    input [9:0] b1;
    input [9:0] b2;
    input [9:0] b3;
    begin
        case (sel)
            2'h0: pick_base = b0;
            2'h1: pick_base = b1;
            2'h2: pick_base = b2;
            default: pick_base = b3;
        endcase
    end
endfunction

wire [9:0] base_a = pick_base(base_sel[`BASE_SEL_SERIAL_A_LSB +: 2], `BASE_COM1, `BASE_COM2,
    `BASE_COM3, `BASE_COM4);
wire [9:0] base_b = pick_base(base_sel[`BASE_SEL_SERIAL_B_LSB +: 2], `BASE_COM2, `BASE_COM1,
    `BASE_COM4, `BASE_COM3);
wire [9:0] base_p = pick_base(base_sel[`BASE_SEL_PRINTER_LSB +: 2], `BASE_LPT2, `BASE_LPT1,
    `BASE_LPT3, `BASE_LPT3);

reg [9:0] addr_s1;
reg [9:0] addr_s2;
reg [4:0] next_select;

// Two functions placed at one base both answer; software must keep them apart
// because the decode has no priority between them.
always @* begin
    next_select = 5'h00;
    next_select[`FN_FLOPPY] = addr_hit(addr_s2, `BASE_FLOPPY, `WIN_8) & enables[`FN_FLOPPY];
    next_select[`FN_SERIAL_A] = addr_hit(addr_s2, base_a, `WIN_8) & enables[`FN_SERIAL_A];
    next_select[`FN_SERIAL_B] = addr_hit(addr_s2, base_b, `WIN_8) & enables[`FN_SERIAL_B];
    next_select[`FN_PRINTER] = addr_hit(addr_s2, base_p, `WIN_4) & enables[`FN_PRINTER];
    next_select[`FN_IDE] = addr_hit(addr_s2, `BASE_IDE, `WIN_8) & enables[`FN_IDE];
    if (chip_down) begin
        next_select = 5'h00;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        addr_s1 <= 10'h000;
        addr_s2 <= 10'h000;
        function_power_down <= `FN_ALL_OFF;
        function_pins_tristate <= `FN_ALL_OFF;
        function_inputs_blocked <= `FN_ALL_OFF;
        function_select <= 5'h00;
        config_image <= 64'h0000000000000000;
    end else begin
        addr_s1 <= host_addr;
        addr_s2 <= addr_s1;
        function_select <= next_select;
        // Power-down only gates clocks/access; data registers in the function stay intact
        function_power_down <= ~enables[4:0] | {5{chip_down}};
        function_pins_tristate <= power_ctl[`PWR_MGMT_TRISTATE_LSB +: 4] == 4'h0 ? {5{chip_down}} :
            ({1'b0, power_ctl[`PWR_MGMT_TRISTATE_LSB +: 4]} | {5{chip_down}});
        function_inputs_blocked <= {1'b0, power_ctl[`PWR_MGMT_BLOCK_LSB +: 4]} | {5{chip_down}};
        for (j = 0; j < 8; j = j + 1) begin
            config_image[j*8 +: 8] <= cfg[j];
        end
    end
end

endmodule // index_data_config_registers

// file: verification/isa_host_model.sv
// Host model: byte cycles on the index/data port pair.
// Assumes the bank's clock; drives on the falling edge.
`timescale 1ns/1ps
module isa_host_model (
    input wire clk,
    output reg io_addr0 = 1'b0,
    output reg io_chip_select_n = 1'b1,
    output reg io_write_n = 1'b1,
    output reg io_read_n = 1'b1,
    output reg [7:0] io_data_in = 8'h00,
    input wire [7:0] io_data_out
);
    // Five clocks each way clears the three-clock sync minimum
    task xfer(input a, input w, input [7:0] d, output [7:0] q);
        begin
            @(negedge clk);
            io_addr0 = a;
            io_data_in = d;
            io_chip_select_n = 1'b0;
            io_write_n = !w;
            io_read_n = w;
            repeat (5) @(negedge clk);
            q = io_data_out;
            io_write_n = 1'b1;
            io_read_n = 1'b1;
            repeat (5) @(negedge clk);
            io_chip_select_n = 1'b1;
            io_data_in = ~d;
        end
    endtask
endmodule // isa_host_model

// file: verification/config_bank_asserts.sv
// Port checker for the config register bank.
// Assumes bind onto the bank; one clock, async low reset.
`timescale 1ns/1ps
module config_bank_asserts (
    input wire clk,
    input wire resetn,
    input wire io_chip_select_n,
    input wire io_write_n,
    input wire io_read_n,
    input wire [7:0] io_data_out,
    input wire io_data_oe,
    input wire [4:0] function_power_down,
    input wire [4:0] function_pins_tristate,
    input wire [4:0] function_inputs_blocked,
    input wire [4:0] function_select,
    input wire [63:0] config_image
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Straps land a few clocks after release, so mappings wait for up
    reg [3:0] age;
    reg [3:0] wage;
    wire up = age == 4'hF;
    wire cd = config_image[16];
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            age <= 4'h0;
            wage <= 4'hF;
        end else begin
            age <= age + {3'h0, !up};
            wage <= io_write_n ? wage + {3'h0, wage != 4'hF} : 4'h0;
        end
    end
    sequence rd_go;
        $fell(io_read_n) && !io_chip_select_n;
    endsequence
    a_read_answer: assert property (rd_go |-> ##[2:4] io_data_oe) else $error("no answer");
    a_oe_release: assert property ($fell(io_data_oe) |-> $past(io_read_n, 3)) else $error("early drop");
    a_data_holds: assert property ($changed(io_data_out) |-> $rose(io_data_oe)) else $error("data moved");
    a_image_write: assert property (up && $changed(config_image) |-> wage <= 4'h7) else $error("stray");
    a_pd_map: assert property (up |-> function_power_down == (~config_image[4:0] | {5{cd}})) else $error("pd");
    a_tri_map: assert property (up |-> function_pins_tristate == {cd, config_image[43:40] | {4{cd}}})
        else $error("tri");
    a_block_map: assert property (up |-> function_inputs_blocked == {cd, config_image[47:44] | {4{cd}}})
        else $error("block");
    a_sel_off: assert property (up |-> (function_select & function_power_down) == 5'h00) else $error("sel");
endmodule // config_bank_asserts
bind index_data_config_registers config_bank_asserts chk (.clk, .resetn, .io_chip_select_n, .io_write_n,
    .io_read_n, .io_data_out, .io_data_oe, .function_power_down, .function_pins_tristate,
    .function_inputs_blocked, .function_select, .config_image);

// file: verification/index_data_config_registers_tb.sv
// Bench for the config register bank.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module index_data_config_registers_tb;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg [63:0] strap_defaults = 64'h0;
    reg [9:0] host_addr = 10'h000;
    wire io_addr0, io_chip_select_n, io_write_n, io_read_n, io_data_oe;
    wire [7:0] io_data_in, io_data_out;
    wire [4:0] function_power_down, function_pins_tristate, function_inputs_blocked, function_select;
    wire [63:0] config_image;
    integer fail_count = 0;
    integer checked = 0;
    integer i;
    reg [7:0] v, q;
    always #5 clk = ~clk;
    index_data_config_registers dut (.clk, .resetn, .strap_defaults, .io_addr0, .io_chip_select_n, .io_write_n,
        .io_read_n, .io_data_in, .io_data_out, .io_data_oe, .host_addr, .function_power_down,
        .function_pins_tristate, .function_inputs_blocked, .function_select, .config_image);
    isa_host_model host (.clk, .io_addr0, .io_chip_select_n, .io_write_n, .io_read_n, .io_data_in, .io_data_out);
    task cmp(input string n, input [63:0] e, input [63:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch %s exp %h got %h", n, e, g);
            end
        end
    endtask
    task wr(input [2:0] k, input [7:0] d);
        reg [7:0] s;
        begin
            host.xfer(1'b0, 1'b1, {5'h00, k}, s);
            host.xfer(1'b1, 1'b1, d, s);
        end
    endtask
    task rd(input [2:0] k, output [7:0] d);
        reg [7:0] s;
        begin
            host.xfer(1'b0, 1'b1, {5'h00, k}, s);
            host.xfer(1'b1, 1'b0, ~s, d);
        end
    endtask
    task end_of_test;
        begin
            $display("checked %0d fail_count %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    function [4:0] exp_pd(input [7:0] en, input cd);
        exp_pd = ~en[4:0] | {5{cd}};
    endfunction
    initial begin
        v = $urandom(32'h04EB7EBC);
        strap_defaults = {$urandom, $urandom};
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        cmp("image", strap_defaults, config_image);
        for (i = 0; i < 8; i = i + 1) begin
            rd(i, q);
            cmp("strap", strap_defaults[8*i +: 8], q);
        end
        for (i = 0; i < 8; i = i + 1) begin
            v = $urandom & ((i == 2) ? 8'hFE : 8'hFF);
            wr(i, v);
            rd(i, q);
            cmp("data", v, q);
            cmp("byte", v, config_image[8*i +: 8]);
        end
        host.xfer(1'b0, 1'b1, 8'hFA, q);
        host.xfer(1'b1, 1'b1, 8'h5C, q);
        host.xfer(1'b0, 1'b0, 8'h00, q);
        cmp("index", 8'hFA, q);
        cmp("reg2", 8'h5C, config_image[23:16]);
        wr(0, 8'h1E);
        wr(1, 8'h00);
        cmp("pd", exp_pd(8'h1E, 1'b0), function_power_down);
        v = $urandom;
        wr(5, v);
        cmp("tri", {1'b0, v[3:0]}, function_pins_tristate);
        cmp("blk", {1'b0, v[7:4]}, function_inputs_blocked);
        host_addr = 10'h3F8;
        repeat (6) @(negedge clk);
        cmp("com1", 1'b1, function_select[1]);
        wr(1, 8'h04);
        host_addr = 10'h2F8;
        repeat (6) @(negedge clk);
        cmp("com2", 1'b1, function_select[1]);
        host_addr = 10'h1F0;
        repeat (6) @(negedge clk);
        cmp("ide", 5'h10, function_select);
        host_addr = 10'h378;
        repeat (6) @(negedge clk);
        cmp("lpt", 5'h08, function_select);
        host_addr = 10'h3F0;
        repeat (6) @(negedge clk);
        cmp("floppy_off", 5'h00, function_select);
        wr(2, 8'h01);
        cmp("down", 5'h1F, function_power_down);
        cmp("down_tri", 5'h1F, function_pins_tristate);
        cmp("down_blk", 5'h1F, function_inputs_blocked);
        cmp("down_sel", 5'h00, function_select);
        cmp("kept", 16'h041E, config_image[15:0]);
        strap_defaults = {$urandom, $urandom};
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        cmp("rst_pd", 5'h1F, function_power_down);
        cmp("rst_image", 64'h0, config_image);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        cmp("image2", strap_defaults, config_image);
        end_of_test;
    end
endmodule // index_data_config_registers_tb
